// >>> can_ctl_defines.svh
`ifndef CAN_CTL_DEFINES_SVH
`define CAN_CTL_DEFINES_SVH
// Register word addresses on the plain port
`define ADDR_MODE_CONTROL     4'h0
`define ADDR_NET_COMPARE      4'h1
`define ADDR_IRQ_CODE         4'h2
`define ADDR_FIFO_SETUP       4'h3
`define ADDR_FIFO_POINTERS    4'h4
`define ADDR_IRQ_FLAGS        4'h5
`define ADDR_IRQ_ENABLES      4'h6
`define ADDR_ERROR_COUNTERS   4'h7
// Field positions
`define F_ABORT_ALL           12
`define F_REQ_MODE_LO         8
`define F_CUR_MODE_LO         5
// Reset values
`define RST_MODE              3'h4
// Idle recessive bits needed before a mode switch
`define IDLE_BITS             4'hb
`define DATA_COMPARE_LENGTH_MAX             5'h11
`endif

// >>> can_ctl_pkg.sv
package can_ctl_pkg;
  // Operating mode codes
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'h0,
    MODE_DISABLE = 3'h1,
    MODE_LOOP    = 3'h2,
    MODE_LISTEN  = 3'h3,
    MODE_CONFIG  = 3'h4,
    MODE_ALL     = 3'h7
  } can_mode_t;
  // Hardware event strobes, one per flag, bit order as the flag register
  typedef struct packed {
    logic invalid_msg;
    logic wakeup;
    logic error;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_buffer;
    logic tx_buffer;
  } can_events_t;
  // Error-state status
  typedef struct packed {
    logic tx_bus_off;
    logic tx_bus_passive;
    logic rx_bus_passive;
    logic tx_warning;
    logic rx_warning;
  } err_state_t;
endpackage

// >>> can_ctl.sv
`timescale 1ns/1ps
`include "can_ctl_defines.svh"
// How it works
// - Loopback ties internal transmit to receive
// - Loopback releases the transmit bus pin
// - Abort-all bit self-clears after all aborted
// - Requested mode field uses documented codes
// - Current mode reads back; resets to configuration
// - Data compare length field, high codes invalid
// - FIFO start buffer field, 0 to 31
// - Flags set by hardware, cleared writing zero
// - Each flag has an enable bit
// - Error counters: tx high, rx low
// - Mode change waits eleven idle recessive bits
// - Configuration clears counters, stops traffic
// - Listen-only: no error flags, no ack
module can_ctl (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    bit_tick,
  input  wire logic                    can_rx_pin,
  output logic                         can_tx_out,
  output logic                         can_tx_oe_n,
  output logic                         core_rx,
  input  wire logic                    core_tx,
  input  wire logic                    core_busy,
  output logic                         core_tx_enable,
  output logic                         core_rx_enable,
  output logic                         core_send_err_ack,
  output logic                         abort_req,
  input  wire logic                    abort_done,
  input  wire can_ctl_pkg::can_events_t events,
  input  wire can_ctl_pkg::err_state_t  err_state,
  input  wire logic                    tx_err_inc,
  input  wire logic                    rx_err_inc,
  output logic                         irq
);
  import can_ctl_pkg::*;

  // Pin synchroniser; first stage is read only by the second
  logic rx_meta_q;
  logic rx_sync_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= can_rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Register state
  can_mode_t   req_mode_q;       // Requested mode
  can_mode_t   cur_mode_q;       // Mode in effect
  logic        abort_q;          // Abort-all request
  logic [4:0]  data_compare_length_q;          // Data compare length
  logic [4:0]  fifo_start_q;     // First FIFO buffer
  logic [6:0]  flags_q;          // Sticky event flags
  logic [6:0]  enables_q;        // Flag enables
  logic [7:0]  tx_err_q;         // Transmit error count
  logic [7:0]  rx_err_q;         // Receive error count
  logic [3:0]  idle_cnt_q;       // Recessive bit run length
  logic [6:0]  irq_code;         // Highest-priority pending code
  logic        wr_mode;
  logic        bus_idle;
  logic        any_warning;
  can_events_t ev;

  assign wr_mode = reg_wr && (reg_addr == `ADDR_MODE_CONTROL);
  assign any_warning = err_state.tx_warning | err_state.rx_warning;
  assign bus_idle = (idle_cnt_q >= `IDLE_BITS) && !core_busy;

  // Loopback feeds transmit to receive; transmit pin released in every mode but MODE_NORMAL and MODE_ALL
  always_comb begin
    core_rx = (cur_mode_q == MODE_LOOP) ? core_tx : rx_sync_q;
    can_tx_out = core_tx;
    can_tx_oe_n = !(cur_mode_q == MODE_NORMAL || cur_mode_q == MODE_ALL);
  end

  // Traffic permissions follow the mode in effect
  always_comb begin
    core_tx_enable = (cur_mode_q == MODE_NORMAL) || (cur_mode_q == MODE_LOOP)
                     || (cur_mode_q == MODE_ALL);
    core_rx_enable = (cur_mode_q != MODE_CONFIG) && (cur_mode_q != MODE_DISABLE);
    core_send_err_ack = core_tx_enable;
  end

  // Count recessive bits on the receive path; any dominant bit restarts it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 4'h0;
    end else if (!core_rx) begin
      idle_cnt_q <= 4'h0;
    end else if (bit_tick && idle_cnt_q < `IDLE_BITS) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end
  end

  // Requested mode; reserved codes are ignored so the request stays valid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_mode_q <= MODE_CONFIG;
    end else if (wr_mode) begin
      case (reg_wdata[`F_REQ_MODE_LO +: 3])
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7: begin
          req_mode_q <= can_mode_t'(reg_wdata[`F_REQ_MODE_LO +: 3]);
        end
        default: begin
          req_mode_q <= req_mode_q;
        end
      endcase
    end
  end

  // Mode switch only on an idle bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_mode_q <= MODE_CONFIG;
    end else if (req_mode_q != cur_mode_q && bus_idle) begin
      cur_mode_q <= req_mode_q;
    end
  end

  // Abort-all: set by software, cleared by hardware when done
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else if (wr_mode && reg_wdata[`F_ABORT_ALL]) begin
      abort_q <= 1'b1;
    end else if (abort_done) begin
      abort_q <= 1'b0;
    end
  end
  assign abort_req = abort_q;

  // Compare length and FIFO start; invalid compare lengths are refused
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_compare_length_q <= 5'h0;
      fifo_start_q <= 5'h0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_NET_COMPARE && reg_wdata[4:0] <= `DATA_COMPARE_LENGTH_MAX) begin
        data_compare_length_q <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `ADDR_FIFO_SETUP) begin
        fifo_start_q <= reg_wdata[4:0];
      end
    end
  end

  // Error flag raised on entering an error state while none is active
  logic err_any;
  logic err_any_q;
  assign err_any = |err_state;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_any_q <= 1'b0;
    end else begin
      err_any_q <= err_any;
    end
  end
  always_comb begin
    ev = events;
    ev.error = events.error | (err_any & !err_any_q);
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= 7'h0;
    end else if (reg_wr && reg_addr == `ADDR_IRQ_FLAGS) begin
      flags_q <= (flags_q & {reg_wdata[7:5], reg_wdata[3:0]}) | ev;
    end else begin
      flags_q <= flags_q | ev;
    end
  end

  // Enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_q <= 7'h0;
    end else if (reg_wr && reg_addr == `ADDR_IRQ_ENABLES) begin
      enables_q <= {reg_wdata[7:5], reg_wdata[3:0]};
    end
  end

  assign irq = |(flags_q & enables_q);

  // Error counters: cleared in configuration, frozen when not active
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_err_q <= 8'h00;
      rx_err_q <= 8'h00;
    end else if (cur_mode_q == MODE_CONFIG) begin
      tx_err_q <= 8'h00;
      rx_err_q <= 8'h00;
    end else if (cur_mode_q != MODE_LISTEN && cur_mode_q != MODE_DISABLE) begin
      if (tx_err_inc && tx_err_q != 8'hff) begin
        tx_err_q <= tx_err_q + 8'h01;
      end
      if (rx_err_inc && rx_err_q != 8'hff) begin
        rx_err_q <= rx_err_q + 8'h01;
      end
    end
  end

  // Interrupt code: pending flag with its own code, error first, enabled or not
  // Buffer and invalid-message events need buffer numbers this block never sees
  always_comb begin
    irq_code = 7'h40;
    if (flags_q[3]) irq_code = 7'h44;
    if (flags_q[2]) irq_code = 7'h43;
    if (flags_q[5]) irq_code = 7'h42;
    if (flags_q[4]) irq_code = 7'h41;
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_MODE_CONTROL: begin
          reg_rdata <= {3'h0, abort_q, 1'b0, req_mode_q, cur_mode_q, 5'h00};
        end
        `ADDR_NET_COMPARE: begin
          reg_rdata <= {11'h000, data_compare_length_q};
        end
        `ADDR_IRQ_CODE: begin
          reg_rdata <= {9'h000, irq_code};
        end
        `ADDR_FIFO_SETUP: begin
          reg_rdata <= {11'h000, fifo_start_q};
        end
        `ADDR_IRQ_FLAGS: begin
          reg_rdata <= {2'h0, err_state, any_warning, flags_q[6:4], 1'b0, flags_q[3:0]};
        end
        `ADDR_IRQ_ENABLES: begin
          reg_rdata <= {8'h00, enables_q[6:4], 1'b0, enables_q[3:0]};
        end
        `ADDR_ERROR_COUNTERS: begin
          reg_rdata <= {tx_err_q, rx_err_q};
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Assertions
  property p_loop;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur_mode_q == MODE_LOOP) |-> (core_rx == core_tx) && can_tx_oe_n;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path wrong");
  property p_mode_wait;
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(cur_mode_q) |-> $past(bus_idle);
  endproperty
  a_mode_wait: assert property (p_mode_wait) else $error("mode changed on busy bus");
  property p_cfg_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur_mode_q == MODE_CONFIG) |=> (tx_err_q == 8'h00 && rx_err_q == 8'h00);
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("counters not cleared");
  property p_listen;
    @(posedge ref_clk) disable iff (!rst_n)
    (cur_mode_q == MODE_LISTEN) |-> !core_send_err_ack ##1 ($stable(tx_err_q) && $stable(rx_err_q));
  endproperty
  a_listen: assert property (p_listen) else $error("listen-only not passive");
  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n)
    irq == |(flags_q & enables_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_set_wins;
    @(posedge ref_clk) disable iff (!rst_n)
    ev.wakeup |=> flags_q[5];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");
  property p_abort;
    @(posedge ref_clk) disable iff (!rst_n)
    (abort_q && abort_done && !wr_mode) |=> !abort_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not cleared");
  property p_data_compare_length;
    @(posedge ref_clk) disable iff (!rst_n)
    data_compare_length_q <= `DATA_COMPARE_LENGTH_MAX;
  endproperty
  a_data_compare_length: assert property (p_data_compare_length) else $error("invalid compare length");
  c_loop: cover property (@(posedge ref_clk) cur_mode_q == MODE_LOOP);
  c_normal: cover property (@(posedge ref_clk) cur_mode_q == MODE_NORMAL);
  c_irq: cover property (@(posedge ref_clk) $rose(irq));
endmodule

// >>> can_bus_node.sv
`timescale 1ns/1ps
// Another node on the shared bus; it also paces the bit time
module can_bus_node #(
  parameter int TICK_DIV = 4  // Clocks per bit time, short to keep runs brief
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic talk,      // High while this node sends a frame
  input  wire logic dut_tx,
  input  wire logic dut_oe_n,
  output logic      bus_rx,
  output logic      bit_tick
);
  logic [3:0] div_q;  // Bit-time divider
  logic       bit_q;  // Own bit, alternates so idle is never mistaken
  // Divider and own bit pattern
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      bit_q <= 1'b0;
    end else if (div_q == 4'(TICK_DIV - 1)) begin
      div_q <= 4'h0;
      bit_q <= talk ? ~bit_q : 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign bit_tick = (div_q == 4'(TICK_DIV - 1));
  // Wired-AND bus with pull-up: released lines read recessive
  assign bus_rx = (talk ? bit_q : 1'b1) & (dut_oe_n | dut_tx);
endmodule

// >>> can_ctl_tb.sv
`timescale 1ns/1ps
`include "can_ctl_defines.svh"
module can_ctl_tb;
  import can_ctl_pkg::*;
  logic        ref_clk, rst_n, reg_wr, reg_rd, core_tx, core_busy;
  logic        abort_done, tx_err_inc, rx_err_inc, talk, bit_tick;
  logic        can_rx_pin, can_tx_out, can_tx_oe_n, core_rx, abort_req, irq;
  logic        core_tx_enable, core_rx_enable, core_send_err_ack;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_q;
  can_events_t events;
  err_state_t  err_state;
  int          mismatches, n_checks;
  time         t0;
  can_ctl dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bit_tick, .can_rx_pin, .can_tx_out, .can_tx_oe_n, .core_rx,
    .core_tx, .core_busy, .core_tx_enable, .core_rx_enable,
    .core_send_err_ack, .abort_req, .abort_done, .events, .err_state,
    .tx_err_inc, .rx_err_inc, .irq);
  can_bus_node node_u (.ref_clk, .rst_n, .talk, .dut_tx(can_tx_out),
    .dut_oe_n(can_tx_oe_n), .bus_rx(can_rx_pin), .bit_tick);
  // Clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // Poll the current mode with a bound, a hang ends the run
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 100; i++) begin
      rd(`ADDR_MODE_CONTROL);
      if (rd_q[7:5] === m) return;
    end
    mismatches++;
    $display("mode wait timed out at %0t", $time);
    final_report();
  endtask
  // Error count pulses, each launched on a rising edge
  task automatic bump(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      tx_err_inc <= 1'b1;
      rx_err_inc <= (i < 2);
      @(posedge ref_clk);
      tx_err_inc <= 1'b0;
      rx_err_inc <= 1'b0;
    end
  endtask
  task automatic t_reset;
    rd(`ADDR_MODE_CONTROL);
    chk({13'h0, rd_q[7:5]}, {13'h0, MODE_CONFIG});
    chk({14'h0, irq, can_tx_oe_n}, 16'h0001);
    rd(`ADDR_ERROR_COUNTERS);
    chk(rd_q, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr(`ADDR_FIFO_SETUP, 16'h001f);
    rd(`ADDR_FIFO_SETUP);
    chk(rd_q, 16'h001f);
    wr(`ADDR_NET_COMPARE, 16'h0011);
    wr(`ADDR_NET_COMPARE, 16'h0012);
    rd(`ADDR_NET_COMPARE);
    chk(rd_q, 16'h0011);
    wr(4'hf, 16'hffff);
    rd(4'hf);
    chk(rd_q, 16'h0000);
    $display("register test done");
  endtask
  task automatic t_flags;
    wr(`ADDR_IRQ_ENABLES, 16'h00ef);
    rd(`ADDR_IRQ_ENABLES);
    chk(rd_q, 16'h00ef);
    @(posedge ref_clk);
    events <= 7'h7f;
    @(posedge ref_clk);
    events <= 7'h00;
    wr(`ADDR_IRQ_FLAGS, 16'h00ff);
    rd(`ADDR_IRQ_FLAGS);
    chk(rd_q, 16'h00ef);
    chk({15'h0, irq}, 16'h0001);
    wr(`ADDR_IRQ_FLAGS, 16'h00ee);
    wr(`ADDR_IRQ_ENABLES, 16'h0001);
    rd(`ADDR_IRQ_FLAGS);
    chk({rd_q[7:0], 7'h0, irq}, 16'hee00);
    wr(`ADDR_IRQ_ENABLES, 16'h0002);
    #1 chk({15'h0, irq}, 16'h0001);
    wr(`ADDR_IRQ_FLAGS, 16'h0000);
    err_state <= 5'h15;
    rd(`ADDR_IRQ_FLAGS);
    chk(rd_q, 16'h2b20);
    rd(`ADDR_IRQ_CODE);
    chk(rd_q, 16'h0041);
    err_state <= 5'h00;
    // Clear with zeros while a new event lands in the same cycle: the event stays
    fork
      wr(`ADDR_IRQ_FLAGS, 16'h0000);
      begin
        @(posedge ref_clk);
        events <= 7'h40;
        @(posedge ref_clk);
        events <= 7'h00;
      end
    join
    rd(`ADDR_IRQ_FLAGS);
    chk(rd_q, 16'h0080);
    $display("flag test done");
  endtask
  task automatic t_counters;
    // Break the idle run well before the request, so the switch cannot race it
    @(posedge ref_clk);
    talk <= 1'b1;
    cyc(8);
    wr(`ADDR_MODE_CONTROL, 16'h0000);
    cyc(60);
    rd(`ADDR_MODE_CONTROL);
    chk({13'h0, rd_q[7:5]}, {13'h0, MODE_CONFIG});
    talk <= 1'b0;
    t0 = $time;
    wait_mode(MODE_NORMAL);
    chk({15'h0, ($time - t0) >= 180}, 16'h0001);
    bump(3);
    rd(`ADDR_ERROR_COUNTERS);
    chk(rd_q, 16'h0302);
    wr(`ADDR_MODE_CONTROL, 16'h0300);
    wait_mode(MODE_LISTEN);
    bump(3);
    rd(`ADDR_ERROR_COUNTERS);
    chk(rd_q, 16'h0302);
    wr(`ADDR_MODE_CONTROL, 16'h0400);
    wait_mode(MODE_CONFIG);
    rd(`ADDR_ERROR_COUNTERS);
    chk(rd_q, 16'h0000);
    rd(`ADDR_IRQ_FLAGS);
    chk(rd_q, 16'h0080);
    $display("counter test done");
  endtask
  task automatic t_modes;
    can_mode_t tbl [6] = '{MODE_NORMAL, MODE_LOOP, MODE_LISTEN, MODE_ALL,
                           MODE_DISABLE, MODE_CONFIG};
    logic      exp_tx;    // Mode lets the engine send
    logic      exp_rx;    // Mode lets the engine receive
    logic      exp_echo;  // A sent dominant bit comes back on the receive path
    foreach (tbl[i]) begin
      exp_tx = tbl[i] inside {MODE_NORMAL, MODE_LOOP, MODE_ALL};
      exp_rx = !(tbl[i] inside {MODE_CONFIG, MODE_DISABLE});
      exp_echo = tbl[i] inside {MODE_LOOP, MODE_NORMAL, MODE_ALL};
      wr(`ADDR_MODE_CONTROL, {5'h00, tbl[i], 8'h00});
      wait_mode(tbl[i]);
      chk({15'h0, can_tx_oe_n}, {15'h0, !(tbl[i] inside {MODE_NORMAL, MODE_ALL})});
      chk({14'h0, core_tx_enable, core_rx_enable}, {14'h0, exp_tx, exp_rx});
      chk({15'h0, core_send_err_ack}, {15'h0, exp_tx});
      @(posedge ref_clk);
      core_tx <= 1'b0;
      cyc(4);
      #1 chk({14'h0, can_tx_out, core_rx}, {14'h0, 1'b0, !exp_echo});
      @(posedge ref_clk);
      core_tx <= 1'b1;
    end
    // Reserved codes leave both fields alone
    for (int c = 5; c < 7; c++) begin
      wr(`ADDR_MODE_CONTROL, {5'h00, 3'(c), 8'h00});
      cyc(60);
      rd(`ADDR_MODE_CONTROL);
      chk({10'h0, rd_q[10:5]}, 16'h0024);
    end
    $display("mode test done");
  endtask
  task automatic t_abort;
    wr(`ADDR_MODE_CONTROL, 16'h1400);
    rd(`ADDR_MODE_CONTROL);
    chk({14'h0, rd_q[12], abort_req}, 16'h0003);
    @(posedge ref_clk);
    abort_done <= 1'b1;
    @(posedge ref_clk);
    abort_done <= 1'b0;
    rd(`ADDR_MODE_CONTROL);
    chk({14'h0, rd_q[12], abort_req}, 16'h0000);
    $display("abort test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence: all inputs defined at time zero, reset for 4 cycles
  initial begin
    {rst_n, reg_wr, reg_rd, core_busy, abort_done, tx_err_inc, rx_err_inc} = '0;
    {core_tx, talk, reg_addr, reg_wdata} = {2'b10, 20'h0};
    events = 7'h00;
    err_state = 5'h00;
    cyc(4);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_flags();
    t_counters();
    t_modes();
    t_abort();
    final_report();
  end
endmodule
